// ==== bench/ccrc_chk.sv ====
// Port-level assertion checker for the checksum/CRC accelerator
`timescale 1ns/10ps
module ccrc_chk
   import ccrc_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_rdata,
   // Status
   input  wire logic        busy,
   input  wire logic        entry_ready
);
   // ************************************************************
   // Shadow of the written configuration
   // ************************************************************
   logic [7:0] cfg_reg;
   logic [2:0] alg_reg;
   logic       mapped;
   logic       idle_push;
   logic       alg_on;
   assign mapped = reg_addr == ADDR_CFG || reg_addr == ADDR_STATUS
                   || reg_addr[15:2] == ADDR_DATA0[15:2];
   assign idle_push = reg_wr && reg_addr == ADDR_DATA0 && !busy && !cfg_reg[CFG_SEED];
   assign alg_on = alg_reg != 3'b000 && alg_reg != 3'b110;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) cfg_reg <= CFG_RESET;
      else if (reg_wr && reg_addr == ADDR_CFG) cfg_reg <= reg_wdata;
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) alg_reg <= 3'b000;
      else if (reg_wr && reg_addr == ADDR_CFG && reg_wdata[2:0] != 3'b111)
         alg_reg <= reg_wdata[2:0];
   end
   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");
   a_cfg_readback: assert property (reg_rd && reg_addr == ADDR_CFG |=>
      reg_rdata == {cfg_reg[7:3], 2'b00, $past(busy)})
      else $error("configuration read mismatch");
   a_status_mode: assert property (reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata[2:0] == alg_reg && reg_rdata[STS_FULL] == !$past(entry_ready))
      else $error("status mode or full flag mismatch");
   a_status_empty: assert property (reg_rd && reg_addr == ADDR_STATUS && !busy |=>
      reg_rdata[STS_EMPTY])
      else $error("empty flag clear while idle");
   a_init_flush: assert property (reg_wr && reg_addr == ADDR_CFG &&
      reg_wdata[2:0] == 3'b111 |=> !busy && entry_ready)
      else $error("init write did not flush");
   a_byte_latency: assert property (idle_push && cfg_reg[7:6] == WID_8 ##1
      !reg_wr [*2] |-> !busy)
      else $error("8-bit word took more than one cycle");
   a_half_latency: assert property (idle_push && cfg_reg[7:6] == WID_16 ##1
      !reg_wr [*3] |-> !busy)
      else $error("16-bit word took more than two cycles");
   a_word_latency: assert property (idle_push && cfg_reg[7:6] == WID_32 ##1
      !reg_wr [*5] |-> !busy)
      else $error("32-bit word took more than four cycles");
   a_word_hold: assert property (idle_push && alg_on && cfg_reg[7:6] == WID_32 ##1
      !reg_wr [*4] |-> busy)
      else $error("32-bit word finished early");
endmodule // ccrc_chk

bind checksum_crc_accelerator ccrc_chk u_chk (.core_clk(core_clk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .busy(busy), .entry_ready(entry_ready));

// ==== bench/cpu_master.sv ====
// CPU-side register bus master model
`timescale 1ns/10ps
module cpu_master
   import ccrc_pkg::*;
(
   // Clock
   input  wire logic        core_clk,
   // Register port
   output logic      [15:0] reg_addr,
   output logic      [7:0]  reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   input  wire logic        entry_ready
);
   initial begin
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Mode first, then the init code
   task automatic set_mode(input logic [4:0] up, input logic [2:0] m);
      wr(ADDR_CFG, {up, m});
      wr(ADDR_CFG, {up, 3'b111});
   endtask
   // High bytes first, low byte last
   task automatic put_word(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) wr(ADDR_DATA0 + 16'(i), w[8*i+:8]);
   endtask
   // Back-to-back low-byte writes, counting the accepted ones
   task automatic burst(input int n, output int acc);
      acc = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         if (reg_wr && entry_ready) acc++;
         reg_addr <= ADDR_DATA0;
         reg_wdata <= 8'h01;
         reg_wr <= 1'b1;
      end
      @(posedge core_clk);
      if (entry_ready) acc++;
      reg_wr <= 1'b0;
   endtask
endmodule // cpu_master

// ==== bench/tb_top.sv ====
// Self-checking testbench for the checksum/CRC accelerator
`timescale 1ns/10ps
module tb_top
   import ccrc_pkg::*;
();
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        busy;
   logic        entry_ready;
   int          error_cnt = 0;
   int          n_compared = 0;
   always #20 core_clk = ~core_clk;
   checksum_crc_accelerator #(.DEPTH(4)) uut (.core_clk(core_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .busy(busy), .entry_ready(entry_ready));
   cpu_master cpu (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .entry_ready(entry_ready));
   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200; i++) begin
         @(posedge core_clk);
         if (busy === 1'b0) return;
      end
      error_cnt++;
      wrap_up();
   endtask
   task automatic get_res(output logic [31:0] r);
      wait_idle();
      for (int i = 0; i < 4; i++) cpu.rd(ADDR_DATA0 + 16'(i), r[8*i+:8]);
   endtask
   function automatic logic [31:0] crc_byte(logic [31:0] acc, logic [7:0] b,
                                            logic [2:0] m, logic rev);
      logic [31:0] poly;
      int          top;
      logic        fb;
      poly = (m == MODE_CRC32) ? POLY_CRC32 :
             (m == MODE_CRC16A) ? {16'h0, POLY_CRC16_A} : {16'h0, POLY_CRC16_B};
      top = (m == MODE_CRC32) ? 31 : 15;
      if (!rev) b = {<<{b}};
      for (int i = 7; i >= 0; i--) begin
         fb = acc[top] ^ b[i];
         acc = acc << 1;
         if (fb) acc = acc ^ poly;
      end
      if (top == 15) acc[31:16] = 16'h0;
      return acc;
   endfunction
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset_values();
      logic [7:0] d;
      cpu.rd(ADDR_CFG, d);
      check("cfg reset", 32'(d), 32'(CFG_RESET));
      cpu.rd(ADDR_STATUS, d);
      check("status reset", 32'(d), 32'h08);
      for (int i = 0; i < 4; i++) begin
         cpu.rd(ADDR_DATA0 + 16'(i), d);
         check("data reset", 32'(d), 32'(DATA_RESET));
      end
      cpu.rd(16'hA07A, d);
      check("unmapped read", 32'(d), 32'h00);
   endtask
   task automatic t_sum8();
      logic [31:0] r;
      for (int nc = 0; nc < 2; nc++) begin
         cpu.set_mode({WID_8, 1'b0, 1'(nc), 1'b0}, MODE_SUM8);
         get_res(r);
         check("sum seed", r, SEED_SUM);
         cpu.wr(ADDR_DATA0, 8'h05);
         cpu.wr(ADDR_DATA0, 8'hFE);
         get_res(r);
         check("sum8", {24'h0, r[7:0]}, nc ? 32'h03 : 32'h04);
      end
   endtask
   task automatic t_sum32_widths();
      logic [31:0] r;
      cpu.set_mode({WID_16, 3'b000}, MODE_SUM32);
      cpu.put_word(32'h1234, 2);
      cpu.put_word(32'h0101, 2);
      get_res(r);
      check("sum32 w16", r, 32'h00001335);
      cpu.wr(ADDR_CFG, {WID_24, 3'b000, MODE_SUM32});
      cpu.put_word(32'h010000, 3);
      get_res(r);
      check("sum32 w24", r, 32'h00011335);
      cpu.wr(ADDR_CFG, {WID_32, 3'b000, MODE_SUM32});
      cpu.put_word(32'h10000000, 4);
      get_res(r);
      check("sum32 w32", r, 32'h10011335);
   endtask
   task automatic t_seed_and_off();
      logic [31:0] r;
      logic [2:0]  offm [2] = '{MODE_OFF, MODE_RSVD};
      cpu.wr(ADDR_CFG, {WID_32, 3'b101, MODE_SUM32});
      cpu.put_word(32'hA5C30F12, 4);
      cpu.wr(ADDR_CFG, {WID_32, 3'b100, MODE_SUM32});
      cpu.put_word(32'h00000001, 4);
      get_res(r);
      check("seeded sum", r, 32'hA5C30F13);
      foreach (offm[i]) begin
         cpu.wr(ADDR_CFG, {WID_8, 3'b000, offm[i]});
         cpu.wr(ADDR_DATA0, 8'h77);
         get_res(r);
         check("idle mode", r, 32'hA5C30F13);
      end
   endtask
   task automatic t_crc();
      logic [31:0] r;
      logic [31:0] e;
      logic [7:0]  bytes [3] = '{8'h31, 8'hA5, 8'h00};
      logic [2:0]  modes [3] = '{MODE_CRC16A, MODE_CRC16B, MODE_CRC32};
      foreach (modes[m]) for (int rev = 0; rev < 2; rev++) begin
         cpu.set_mode({WID_8, 1'(rev), 2'b00}, modes[m]);
         e = (modes[m] == MODE_CRC32) ? SEED_CRC32 : SEED_CRC16;
         get_res(r);
         check("crc seed", r, e);
         foreach (bytes[i]) begin
            cpu.wr(ADDR_DATA0, bytes[i]);
            e = crc_byte(e, bytes[i], modes[m], 1'(rev));
         end
         get_res(r);
         check("crc value", r, e);
      end
   endtask
   task automatic t_fifo();
      logic [31:0] r;
      int          acc;
      cpu.set_mode({WID_32, 3'b000}, MODE_SUM32);
      cpu.put_word(32'h0, 4);
      cpu.burst(12, acc);
      check("refused on full", 32'(acc < 12), 32'h1);
      get_res(r);
      check("accepted count", r, 32'(acc));
      cpu.burst(6, acc);
      cpu.wr(ADDR_CFG, {WID_32, 3'b000, 3'b111});
      get_res(r);
      check("abort to seed", r, SEED_SUM);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset_values();
      t_sum8();
      t_sum32_widths();
      t_seed_and_off();
      t_crc();
      t_fifo();
      wrap_up();
   end
endmodule // tb_top

// ==== rtl/ccrc_byte_step.sv ====
// One-byte update step for the checksum and CRC algorithms
`timescale 1ns/10ps
module ccrc_byte_step
   import ccrc_pkg::*;
(
   // Current state and input byte
   input  wire logic [31:0] acc_in,
   input  wire logic [7:0]  data_byte,
   input  wire logic [1:0]  lane,
   input  wire mode_t       mode,
   input  wire logic        carry_discard,
   // Updated state
   output logic      [31:0] acc_out
);

   // Add with optional end-around carry at a chosen width
   function automatic logic [31:0] add_wrap(input logic [31:0] a, input logic [31:0] b,
                                            input logic wide, input logic nc);
      logic [32:0] s;
      logic [8:0]  s8;
      s  = {1'b0, a} + {1'b0, b};
      s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
      if (wide) begin
         add_wrap = nc ? s[31:0] : s[31:0] + {31'h0, s[32]};
      end else begin
         add_wrap = {24'h0, nc ? s8[7:0] : s8[7:0] + {7'h0, s8[8]}};
      end
   endfunction

   // MSB-first CRC over one byte
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d,
                                            input logic [31:0] poly, input logic wide);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = (wide ? r[31] : r[15]) ^ d[i];
         r  = {r[30:0], 1'b0} ^ (fb ? poly : 32'h0);
      end
      crc_step = wide ? r : {16'h0, r[15:0]};
   endfunction

   always_comb begin
      case (mode)
         MODE_SUM8:   acc_out = add_wrap(acc_in, {24'h0, data_byte}, 1'b0, carry_discard);
         MODE_SUM32:  acc_out = add_wrap(acc_in, {24'h0, data_byte} << {lane, 3'b000},
                                         1'b1, carry_discard);
         MODE_CRC16A: acc_out = crc_step(acc_in, data_byte, {16'h0, POLY_CRC16_A}, 1'b0);
         MODE_CRC16B: acc_out = crc_step(acc_in, data_byte, {16'h0, POLY_CRC16_B}, 1'b0);
         MODE_CRC32:  acc_out = crc_step(acc_in, data_byte, POLY_CRC32, 1'b1);
         default:     acc_out = acc_in;
      endcase
   end

endmodule // ccrc_byte_step

// ==== rtl/ccrc_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module ccrc_fifo
   import ccrc_pkg::*;
#(
   parameter int WIDTH = 35,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   // Status
   output logic                  full,
   output logic                  empty
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign full      = (count_reg == (AW+1)'(DEPTH));
   assign empty     = (count_reg == '0);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end

endmodule // ccrc_fifo

// ==== rtl/ccrc_pkg.sv ====
// Constants, field layout and encodings of the checksum/CRC accelerator
package ccrc_pkg;

   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam logic [15:0] ADDR_CFG    = 16'hA078;
   localparam logic [15:0] ADDR_STATUS = 16'hA079;
   localparam logic [15:0] ADDR_DATA0  = 16'hA07C;
   localparam logic [15:0] ADDR_DATA1  = 16'hA07D;
   localparam logic [15:0] ADDR_DATA2  = 16'hA07E;
   localparam logic [15:0] ADDR_DATA3  = 16'hA07F;

   // ************************************************************
   // Configuration and status field positions
   // ************************************************************
   localparam int CFG_WIDTH_LSB = 6;
   localparam int CFG_REVERSE   = 5;
   localparam int CFG_CARRY_DISCARD = 4;
   localparam int CFG_SEED      = 3;
   localparam int CFG_BUSY      = 0;
   localparam int STS_FULL      = 4;
   localparam int STS_EMPTY     = 3;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0]  CFG_RESET  = 8'h00;
   localparam logic [7:0]  DATA_RESET = 8'h00;
   localparam logic [31:0] SEED_SUM   = 32'h00000000;
   localparam logic [31:0] SEED_CRC16 = 32'h0000FFFF;
   localparam logic [31:0] SEED_CRC32 = 32'hFFFFFFFF;

   // ************************************************************
   // Polynomials and buffering
   // ************************************************************
   localparam logic [15:0] POLY_CRC16_A = 16'h8005;
   localparam logic [15:0] POLY_CRC16_B = 16'h1021;
   localparam logic [31:0] POLY_CRC32   = 32'h04C11DB7;
   localparam int          FIFO_DEPTH   = 16;

   // ************************************************************
   // Encodings
   // ************************************************************
   typedef enum logic [2:0] {
      MODE_OFF    = 3'b000,
      MODE_SUM8   = 3'b001,
      MODE_SUM32  = 3'b010,
      MODE_CRC16A = 3'b011,
      MODE_CRC16B = 3'b100,
      MODE_CRC32  = 3'b101,
      MODE_RSVD   = 3'b110,
      MODE_INIT   = 3'b111
   } mode_t;

   typedef enum logic [1:0] {
      WID_8  = 2'b00,
      WID_16 = 2'b01,
      WID_24 = 2'b10,
      WID_32 = 2'b11
   } width_t;

endpackage

// ==== rtl/checksum_crc_accelerator.sv ====
// Checksum/CRC accelerator with byte-wide register port and input FIFO
// Function
// - Input words of 8, 16, 24 or 32 bits, chosen by two-bit width field.
// - An 8-bit word is folded into the result in one clock cycle.
// - A 16-bit word is folded into the result in two clock cycles.
// - A 32-bit word is folded into the result in four clock cycles.
// - Writing 111 after a mode clears state and loads default seed.
// - High data bytes written first; low-byte write completes entry and starts work.
// - With seed entry set, data-port words load the seed instead of being processed.
// - Result reads straight from data port, unaffected by bit-order settings.
`timescale 1ns/10ps
module checksum_crc_accelerator
   import ccrc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Status
   output logic             busy,
   output logic             entry_ready
);

   // ************************************************************
   // Types and declarations
   // ************************************************************
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } state_t;

   localparam int EW = 35;

   width_t      input_width_select_reg;
   logic        reverse_reg;
   logic        carry_discard_reg;
   logic        seed_entry_reg;
   mode_t       algorithm_select_reg;
   logic [7:0]  hold1_reg;
   logic [7:0]  hold2_reg;
   logic [7:0]  hold3_reg;
   logic [31:0] acc_reg;
   logic [31:0] acc_next;
   logic [7:0]  reg_rdata_next;
   state_t      state_reg;
   state_t      state_next;
   logic [31:0] word_reg;
   logic [1:0]  left_reg;
   logic [1:0]  left_next;
   logic [1:0]  step_reg;
   logic [1:0]  step_next;
   logic [1:0]  width_word_reg;

   logic          wr_cfg;
   logic          wr_low;
   logic          init_cmd;
   logic          push_valid;
   logic [EW-1:0] push_data;
   logic          pop_valid;
   logic          pop_ready;
   logic [EW-1:0] pop_data;
   logic          fifo_full;
   logic          fifo_empty;
   logic [31:0]   src_word;
   logic [1:0]    src_width;
   logic [1:0]    lane;
   logic [7:0]    lane_byte;
   logic [7:0]    step_byte;
   logic [31:0]   step_out;
   logic          do_step;
   logic          engine_on;

   // Pick byte by lane index
   function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] idx);
      pick_byte = w[{idx, 3'b000} +: 8];
   endfunction

   // Mirror bit order of one byte
   function automatic logic [7:0] mirror(input logic [7:0] b);
      for (int i = 0; i < 8; i++) mirror[i] = b[7-i];
   endfunction

   // Seed value for an algorithm
   function automatic logic [31:0] default_seed(input mode_t m);
      case (m)
         MODE_CRC16A, MODE_CRC16B: default_seed = SEED_CRC16;
         MODE_CRC32:               default_seed = SEED_CRC32;
         default:                  default_seed = SEED_SUM;
      endcase
   endfunction

   // ************************************************************
   // Register write decode
   // ************************************************************
   assign wr_cfg   = reg_wr && (reg_addr == ADDR_CFG);
   assign wr_low   = reg_wr && (reg_addr == ADDR_DATA0);
   assign init_cmd = wr_cfg && (reg_wdata[2:0] == MODE_INIT);
   assign engine_on = (algorithm_select_reg != MODE_OFF) && (algorithm_select_reg != MODE_RSVD);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         input_width_select_reg <= width_t'(CFG_RESET[7:6]);
         reverse_reg            <= CFG_RESET[CFG_REVERSE];
         carry_discard_reg      <= CFG_RESET[CFG_CARRY_DISCARD];
         seed_entry_reg         <= CFG_RESET[CFG_SEED];
         algorithm_select_reg   <= mode_t'(CFG_RESET[2:0]);
      end else if (wr_cfg) begin
         input_width_select_reg <= width_t'(reg_wdata[CFG_WIDTH_LSB +: 2]);
         reverse_reg            <= reg_wdata[CFG_REVERSE];
         carry_discard_reg      <= reg_wdata[CFG_CARRY_DISCARD];
         seed_entry_reg         <= reg_wdata[CFG_SEED];
         if (!init_cmd) begin
            algorithm_select_reg <= mode_t'(reg_wdata[2:0]);
         end
      end
   end

   // High bytes are held until the low byte completes the word
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold1_reg <= DATA_RESET;
         hold2_reg <= DATA_RESET;
         hold3_reg <= DATA_RESET;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_DATA1) hold1_reg <= reg_wdata;
         if (reg_addr == ADDR_DATA2) hold2_reg <= reg_wdata;
         if (reg_addr == ADDR_DATA3) hold3_reg <= reg_wdata;
      end
   end

   // ************************************************************
   // Entry FIFO
   // ************************************************************
   assign push_valid = wr_low && (engine_on || seed_entry_reg);
   assign push_data  = {seed_entry_reg, input_width_select_reg,
                        hold3_reg, hold2_reg, hold1_reg, reg_wdata};
   assign entry_ready = !fifo_full;

   ccrc_fifo #(
      .WIDTH (EW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .flush     (init_cmd),
      .in_valid  (push_valid),
      .in_ready  (),
      .in_data   (push_data),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_data),
      .full      (fifo_full),
      .empty     (fifo_empty)
   );

   // ************************************************************
   // Byte engine
   // ************************************************************
   assign src_word  = (state_reg == ST_IDLE) ? pop_data[31:0] : word_reg;
   assign src_width = (state_reg == ST_IDLE) ? pop_data[33:32] : width_word_reg;
   assign pop_ready = (state_reg == ST_IDLE);

   // LSB-first order walks lanes upward, MSB-first downward
   always_comb begin
      lane = step_reg;
      if (state_reg == ST_IDLE) begin
         lane = reverse_reg ? src_width : 2'b00;
      end
   end

   assign lane_byte = pick_byte(src_word, lane);
   assign step_byte = (reverse_reg || algorithm_select_reg inside {MODE_SUM8, MODE_SUM32}) ?
                      lane_byte : mirror(lane_byte);
   assign do_step   = (state_reg == ST_RUN) ||
                      (pop_valid && !pop_data[34] && engine_on);

   ccrc_byte_step u_step (
      .acc_in        (acc_reg),
      .data_byte     (step_byte),
      .lane          (lane),
      .mode          (algorithm_select_reg),
      .carry_discard (carry_discard_reg),
      .acc_out       (step_out)
   );

   always_comb begin
      state_next = state_reg;
      left_next  = left_reg;
      step_next  = step_reg;
      case (state_reg)
         ST_IDLE: begin
            if (do_step && (src_width != WID_8)) begin
               state_next = ST_RUN;
               left_next  = src_width - 2'd1;
               step_next  = reverse_reg ? src_width - 2'd1 : 2'd1;
            end
         end
         ST_RUN: begin
            step_next = reverse_reg ? step_reg - 2'd1 : step_reg + 2'd1;
            left_next = left_reg - 2'd1;
            if (left_reg == 2'd0) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_comb begin
      acc_next = acc_reg;
      if (init_cmd) begin
         acc_next = default_seed(algorithm_select_reg);
      end else if (state_reg == ST_IDLE && pop_valid && pop_data[34]) begin
         acc_next = pop_data[31:0];
      end else if (do_step) begin
         acc_next = step_out;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg      <= ST_IDLE;
         left_reg       <= 2'd0;
         step_reg       <= 2'd0;
         word_reg       <= 32'h00000000;
         width_word_reg <= WID_8;
      end else if (init_cmd) begin
         state_reg      <= ST_IDLE;
         left_reg       <= 2'd0;
         step_reg       <= 2'd0;
      end else begin
         state_reg <= state_next;
         left_reg  <= left_next;
         step_reg  <= step_next;
         if (state_reg == ST_IDLE && pop_valid) begin
            word_reg       <= pop_data[31:0];
            width_word_reg <= pop_data[33:32];
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_reg <= SEED_SUM;
      end else begin
         acc_reg <= acc_next;
      end
   end

   assign busy = (state_reg == ST_RUN) || !fifo_empty;

   // ************************************************************
   // Register read
   // ************************************************************
   always_comb begin
      case (reg_addr)
         ADDR_CFG:    reg_rdata_next = {input_width_select_reg, reverse_reg, carry_discard_reg,
                                        seed_entry_reg, 2'b00, busy};
         ADDR_STATUS: reg_rdata_next = {3'b000, fifo_full, fifo_empty, algorithm_select_reg};
         ADDR_DATA0:  reg_rdata_next = pick_byte(acc_reg, 2'd0);
         ADDR_DATA1:  reg_rdata_next = pick_byte(acc_reg, 2'd1);
         ADDR_DATA2:  reg_rdata_next = pick_byte(acc_reg, 2'd2);
         ADDR_DATA3:  reg_rdata_next = pick_byte(acc_reg, 2'd3);
         default:     reg_rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= reg_rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // checksum_crc_accelerator
